// ### hw/bprb_device.sv
// Register bank of the protection front end, reached over the register access link.
// Assumes fault conditions and the wake pin arrive asynchronously; srst stands for power-on reset.
`timescale 1ns/10ps
module bprb_device
  import bprb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  bprb_link_if.device      link,
  input  wire logic        external_overheat_cond,
  input  wire logic        internal_overheat_cond,
  input  wire logic        load_failure_cond,
  input  wire logic        discharge_short_cond,
  input  wire logic        discharge_overcurrent_cond,
  input  wire logic        charge_overcurrent_cond,
  input  wire logic        wake_pin,
  output logic             wake_pin_status,
  output logic [5:0]       fault_flags,
  output logic [3:0]       analog_select,
  output logic [3:0]       user_flags,
  output logic             sleep_force,
  output logic             load_monitor_connect,
  output logic             charge_switch_on,
  output logic             discharge_switch_on,
  output logic [7:0]       discharge_settings,
  output logic [7:0]       charge_settings,
  output logic [7:0]       feature_settings,
  output logic             force_por_pulse
);
  typedef struct packed {
    logic [5:0] faults;
    logic       wake_status;
    logic [3:0] aout;
    logic       user_flag_a;
    logic       user_flag_b;
    logic       user_flag_c;
    logic       user_flag_d;
    logic       sleep;
    logic       load_mon;
    logic       chg_on;
    logic       dis_on;
    logic [7:0] dset;
    logic [7:0] cset;
    logic [7:0] fset;
    logic       feature_write_enable;
    logic       charge_write_enable;
    logic       discharge_write_enable;
    logic       force_por;
    logic       taken;
    logic       ack;
    logic [7:0] rdata;
  } bprb_dev_state_type;

  bprb_dev_state_type state_reg;
  bprb_dev_state_type state_next;
  logic [6:0]         sync_in;
  logic [6:0]         sync_val;
  logic [5:0]         cond;
  logic               take;
  logic               wr;
  logic               rd;
  logic               wake_now;
  logic               trip;
  logic [7:0]         rd_value;

  assign sync_in = {wake_pin, external_overheat_cond, internal_overheat_cond, load_failure_cond,
                    discharge_short_cond, discharge_overcurrent_cond, charge_overcurrent_cond};

  bprb_sync #(.WIDTH(7)) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (sync_in),
    .sync_out (sync_val)
  );

  always_comb begin
    state_next           = state_reg;
    state_next.ack       = 1'b0;
    state_next.force_por = 1'b0;
    take     = link.req && !state_reg.taken;
    wr       = take && link.we;
    rd       = take && !link.we;
    state_next.taken = link.req;
    state_next.ack   = take;

    // Load failure only counts while the load monitor is connected
    cond = sync_val[5:0];
    cond[FLT_LOAD_FAIL_BIT] = sync_val[FLT_LOAD_FAIL_BIT] && state_reg.load_mon;

    wake_now = !state_reg.fset[FEAT_WAKE_DIS_BIT]
               && !(sync_val[6] ^ state_reg.fset[FEAT_WAKE_POL_BIT]);  // [R13]
    state_next.wake_status = wake_now;  // [R4]

    // A read clears only faults that are gone; a present fault wins over the clear
    if (rd && link.addr == ADDR_FAULT_STATUS) begin
      state_next.faults = cond;  // [R3] [R12]
    end else begin
      state_next.faults = state_reg.faults | cond;  // [R2] [R12]
    end

    if (wr) begin
      case (link.addr)
        ADDR_ANALOG_SELECT: begin
          state_next.user_flag_b = link.wdata[7];  // [R1]
          state_next.user_flag_a = link.wdata[6];
          state_next.aout        = link.wdata[3:0];
        end
        ADDR_SWITCH_DRIVE: begin
          state_next.sleep    = link.wdata[DRV_SLEEP_BIT];  // [R8]
          state_next.load_mon = link.wdata[DRV_LOAD_MON_BIT];
          state_next.chg_on   = link.wdata[DRV_CHARGE_BIT];  // [R10]
          state_next.dis_on   = link.wdata[DRV_DISCHARGE_BIT];
        end
        ADDR_DISCHARGE_SET: begin
          if (state_reg.discharge_write_enable) begin
            state_next.dset = link.wdata;  // [R11]
          end
        end
        ADDR_CHARGE_SET: begin
          if (state_reg.charge_write_enable) begin
            state_next.cset = link.wdata;  // [R11]
          end
        end
        ADDR_FEATURE_SET: begin
          if (state_reg.feature_write_enable) begin
            // Force-reset is an action, not a setting, so it never sticks
            state_next.fset = link.wdata & ~(8'h01 << FEAT_FORCE_POR_BIT);  // [R11]
            state_next.force_por = link.wdata[FEAT_FORCE_POR_BIT];  // [R1]
          end
        end
        ADDR_WRITE_GUARD: begin
          state_next.feature_write_enable   = link.wdata[GUARD_FEATURE_BIT];
          state_next.charge_write_enable    = link.wdata[GUARD_CHARGE_BIT];
          state_next.discharge_write_enable = link.wdata[GUARD_DISCHARGE_BIT];
          state_next.user_flag_d            = link.wdata[4];
          state_next.user_flag_c            = link.wdata[3];
        end
        default: begin
          // Status, unused and reserved addresses take no write
          state_next.aout = state_reg.aout;  // [R14]
        end
      endcase
    end

    // Wake edge beats a same-cycle sleep write, so the pack cannot miss a wake
    if (wake_now && !state_reg.wake_status) begin
      state_next.sleep = 1'b0;  // [R8]
    end

    trip = (cond[FLT_SHORT_BIT]  && !state_reg.dset[DSET_SC_DISABLE_BIT])
        || (cond[FLT_DIS_OC_BIT] && !state_reg.dset[DSET_OC_DISABLE_BIT])
        || (cond[FLT_CHG_OC_BIT] && !state_reg.cset[CSET_OC_DISABLE_BIT]);
    if (trip) begin
      state_next.chg_on = 1'b0;  // [R9]
      state_next.dis_on = 1'b0;  // [R9]
    end

    case (link.addr)
      ADDR_CONFIG_STATUS: rd_value = {2'b00, SINGLE_FRONT_END_VALUE, state_reg.wake_status, 4'h0};  // [R2]
      ADDR_FAULT_STATUS:  rd_value = {2'b00, state_reg.faults};
      ADDR_ANALOG_SELECT: rd_value = {state_reg.user_flag_b, state_reg.user_flag_a, 2'b00, state_reg.aout};
      ADDR_SWITCH_DRIVE:  rd_value = {state_reg.sleep, state_reg.load_mon, 4'h0,
                                      state_reg.chg_on, state_reg.dis_on};  // [R10]
      ADDR_DISCHARGE_SET: rd_value = state_reg.dset;
      ADDR_CHARGE_SET:    rd_value = state_reg.cset;
      ADDR_FEATURE_SET:   rd_value = state_reg.fset;
      ADDR_WRITE_GUARD:   rd_value = {state_reg.feature_write_enable, state_reg.charge_write_enable,
                                      state_reg.discharge_write_enable, state_reg.user_flag_d,
                                      state_reg.user_flag_c, 3'b000};
      default:            rd_value = RESET_VALUE;
    endcase
    if (rd) begin
      state_next.rdata = rd_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;  // [R8]
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.ack             = state_reg.ack;
  assign link.rdata           = state_reg.rdata;
  assign wake_pin_status      = state_reg.wake_status;
  assign fault_flags          = state_reg.faults;
  assign analog_select        = state_reg.aout;
  assign user_flags           = {state_reg.user_flag_d, state_reg.user_flag_c,
                                 state_reg.user_flag_b, state_reg.user_flag_a};
  assign sleep_force          = state_reg.sleep;
  assign load_monitor_connect = state_reg.load_mon;
  assign charge_switch_on     = state_reg.chg_on;  // [R10]
  assign discharge_switch_on  = state_reg.dis_on;
  assign discharge_settings   = state_reg.dset;
  assign charge_settings      = state_reg.cset;
  assign feature_settings     = state_reg.fset;
  assign force_por_pulse      = state_reg.force_por;
endmodule // bprb_device

// ### hw/bprb_pkg.sv
// Constants shared by the battery-protect register bank ends: map, field positions, host controller map.
// Assumes both ends run on one clock, clk_sys at 50 MHz, with synchronous active-high reset.
// Function
// [R1] Written one bits take their stated effect
// [R2] Status bit reads one while condition present
// [R3] Fault flags latched, cleared by status read
// [R4] Other status bits follow condition directly
// [R5] Host writes zero into reserved bits
// [R6] Host never writes addresses 09H to FFH
// [R7] Host ignores reserved bits on reads
// [R8] Sleep cleared by reset, wake edge, write
// [R9] Enabled faults clear both switch-on bits
// [R10] Switch bits drive outputs, read drive state
// [R11] Guarded settings writes need enable bit set
// [R12] Read clears flag only when fault gone
// [R13] Wake status follows pin and polarity
// [R14] Writes to status registers are ignored
package bprb_pkg;
  localparam logic [7:0] ADDR_CONFIG_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_FAULT_STATUS   = 8'h01;
  localparam logic [7:0] ADDR_UNUSED_SLOT    = 8'h02;
  localparam logic [7:0] ADDR_ANALOG_SELECT  = 8'h03;
  localparam logic [7:0] ADDR_SWITCH_DRIVE   = 8'h04;
  localparam logic [7:0] ADDR_DISCHARGE_SET  = 8'h05;
  localparam logic [7:0] ADDR_CHARGE_SET     = 8'h06;
  localparam logic [7:0] ADDR_FEATURE_SET    = 8'h07;
  localparam logic [7:0] ADDR_WRITE_GUARD    = 8'h08;
  localparam logic [7:0] ADDR_LAST_VALID     = 8'h08;

  localparam int CFG_SINGLE_BIT      = 5;
  localparam int CFG_WAKE_BIT        = 4;
  localparam int FLT_LOAD_FAIL_BIT   = 3;
  localparam int FLT_SHORT_BIT       = 2;
  localparam int FLT_DIS_OC_BIT      = 1;
  localparam int FLT_CHG_OC_BIT      = 0;
  localparam int DRV_SLEEP_BIT       = 7;
  localparam int DRV_LOAD_MON_BIT    = 6;
  localparam int DRV_CHARGE_BIT      = 1;
  localparam int DRV_DISCHARGE_BIT   = 0;
  localparam int DSET_OC_DISABLE_BIT = 7;
  localparam int DSET_SC_DISABLE_BIT = 4;
  localparam int CSET_OC_DISABLE_BIT = 7;
  localparam int FEAT_FORCE_POR_BIT  = 2;
  localparam int FEAT_WAKE_DIS_BIT   = 1;
  localparam int FEAT_WAKE_POL_BIT   = 0;
  localparam int GUARD_FEATURE_BIT   = 7;
  localparam int GUARD_CHARGE_BIT    = 6;
  localparam int GUARD_DISCHARGE_BIT = 5;

  localparam logic       SINGLE_FRONT_END_VALUE = 1'b1;
  localparam logic [7:0] RESET_VALUE            = 8'h00;
  localparam logic [5:0] FAULT_RESET_VALUE      = 6'h00;

  // Bits that exist in each register; the rest are reserved
  localparam logic [7:0] MASK_CONFIG_STATUS = 8'h30;
  localparam logic [7:0] MASK_FAULT_STATUS  = 8'h3F;
  localparam logic [7:0] MASK_ANALOG_SELECT = 8'hCF;
  localparam logic [7:0] MASK_SWITCH_DRIVE  = 8'hC3;
  localparam logic [7:0] MASK_SETTINGS      = 8'hFF;
  localparam logic [7:0] MASK_WRITE_GUARD   = 8'hF8;
  localparam logic [7:0] MASK_NONE          = 8'h00;

  function automatic logic [7:0] bprb_field_mask(input logic [7:0] addr);
    case (addr)
      ADDR_CONFIG_STATUS: bprb_field_mask = MASK_CONFIG_STATUS;
      ADDR_FAULT_STATUS:  bprb_field_mask = MASK_FAULT_STATUS;
      ADDR_ANALOG_SELECT: bprb_field_mask = MASK_ANALOG_SELECT;
      ADDR_SWITCH_DRIVE:  bprb_field_mask = MASK_SWITCH_DRIVE;
      ADDR_DISCHARGE_SET: bprb_field_mask = MASK_SETTINGS;
      ADDR_CHARGE_SET:    bprb_field_mask = MASK_SETTINGS;
      ADDR_FEATURE_SET:   bprb_field_mask = MASK_SETTINGS;
      ADDR_WRITE_GUARD:   bprb_field_mask = MASK_WRITE_GUARD;
      default:            bprb_field_mask = MASK_NONE;
    endcase
  endfunction

  // Host controller APB map
  localparam logic [7:0] APB_COMMAND    = 8'h00;
  localparam logic [7:0] APB_STATUS     = 8'h04;
  localparam logic [7:0] APB_IRQ_STATUS = 8'h08;
  localparam logic [7:0] APB_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0] APB_IRQ_ENABLE = 8'h10;
  localparam int CMD_WRITE_BIT    = 16;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_REFUSED_BIT  = 1;
  localparam logic [1:0] IRQ_RESET_VALUE = 2'h0;
endpackage

// ### hw/bprb_link_if.sv
// Register access link between the pack controller and the protection front end.
// Assumes both ends share clk_sys; req is a level held until ack, ack is a one-cycle pulse.
`timescale 1ns/10ps
interface bprb_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host   (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// ### hw/bprb_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
module bprb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] value;
  } bprb_sync_state_type;

  bprb_sync_state_type state_reg;
  bprb_sync_state_type state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
    state_next.stage3 = state_reg.stage2;
    // A lane moves only once two settled stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (state_reg.stage2[i] == state_reg.stage3[i]) begin
        state_next.value[i] = state_reg.stage3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.value;
endmodule // bprb_sync

// ### hw/bprb_host.sv
// Pack controller end: APB slave for software, drives the register access link.
// Assumes APB master on clk_sys; one link transfer in flight at a time.
`timescale 1ns/10ps
module bprb_host
  import bprb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  bprb_link_if.host        link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_GAP} bprb_link_state_type;

  typedef struct packed {
    bprb_link_state_type fsm;
    logic                req;
    logic                we;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    logic [7:0]          guard_shadow;
    logic [1:0]          irq_status;
    logic [1:0]          irq_enable;
    logic                irq;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } bprb_host_state_type;

  bprb_host_state_type state_reg;
  bprb_host_state_type state_next;
  logic                apb_do;
  logic [1:0]          events;
  logic [1:0]          clears;
  logic [7:0]          cmd_addr;
  logic                cmd_write;
  logic                guarded_ok;
  logic                mapped;

  always_comb begin
    state_next         = state_reg;
    events             = 2'b00;
    clears             = 2'b00;
    cmd_addr           = pwdata[7:0];
    cmd_write          = pwdata[CMD_WRITE_BIT];
    apb_do             = psel && penable && state_reg.pready;
    state_next.pready  = psel && penable && !state_reg.pready;
    mapped = (paddr == APB_COMMAND) || (paddr == APB_STATUS) || (paddr == APB_IRQ_STATUS)
          || (paddr == APB_IRQ_CLEAR) || (paddr == APB_IRQ_ENABLE);
    state_next.pslverr = psel && penable && !state_reg.pready && !mapped;
    case (cmd_addr)
      ADDR_DISCHARGE_SET: guarded_ok = state_reg.guard_shadow[GUARD_DISCHARGE_BIT];  // [R11]
      ADDR_CHARGE_SET:    guarded_ok = state_reg.guard_shadow[GUARD_CHARGE_BIT];
      ADDR_FEATURE_SET:   guarded_ok = state_reg.guard_shadow[GUARD_FEATURE_BIT];
      default:            guarded_ok = 1'b1;
    endcase

    if (psel && penable && !state_reg.pready) begin
      case (paddr)
        APB_STATUS:     state_next.prdata = {16'h0000, state_reg.rdata, 7'h00, state_reg.fsm != ST_IDLE};
        APB_IRQ_STATUS: state_next.prdata = {30'h0000_0000, state_reg.irq_status};
        APB_IRQ_ENABLE: state_next.prdata = {30'h0000_0000, state_reg.irq_enable};
        default:        state_next.prdata = 32'h0000_0000;
      endcase
    end

    if (apb_do && pwrite) begin
      case (paddr)
        APB_COMMAND: begin
          if (state_reg.fsm == ST_IDLE) begin
            if (cmd_addr > ADDR_LAST_VALID || (cmd_write && !guarded_ok)) begin
              events[IRQ_REFUSED_BIT] = 1'b1;  // [R6] [R11]
            end else begin
              state_next.fsm   = ST_REQ;
              state_next.req   = 1'b1;
              state_next.we    = cmd_write;
              state_next.addr  = cmd_addr;
              state_next.wdata = pwdata[15:8] & bprb_field_mask(cmd_addr);  // [R5]
              if (cmd_write && cmd_addr == ADDR_WRITE_GUARD) begin
                state_next.guard_shadow = pwdata[15:8];
              end
            end
          end
        end
        APB_IRQ_CLEAR:  clears = pwdata[1:0];
        APB_IRQ_ENABLE: state_next.irq_enable = pwdata[1:0];
        default:        state_next.irq_enable = state_reg.irq_enable;
      endcase
    end

    case (state_reg.fsm)
      ST_REQ: begin
        if (link.ack) begin
          state_next.req   = 1'b0;
          state_next.fsm   = ST_GAP;
          state_next.rdata = link.rdata & bprb_field_mask(state_reg.addr);  // [R7]
          events[IRQ_DONE_BIT] = 1'b1;
        end
      end
      ST_GAP:  state_next.fsm = ST_IDLE;
      ST_IDLE: state_next.fsm = state_next.fsm;
      default: state_next.fsm = ST_IDLE;
    endcase

    // A new event outlasts a clear in the same cycle
    state_next.irq_status = (state_reg.irq_status & ~clears) | events;
    state_next.irq        = |(state_next.irq_status & state_next.irq_enable);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.req   = state_reg.req;
  assign link.we    = state_reg.we;
  assign link.addr  = state_reg.addr;
  assign link.wdata = state_reg.wdata;
  assign prdata     = state_reg.prdata;
  assign pready     = state_reg.pready;
  assign pslverr    = state_reg.pslverr;
  assign irq        = state_reg.irq;
endmodule // bprb_host

// ### verification/bprb_assertions.sv
// Link checker for the register bank: timing of req/ack and what the host may put on the link.
// Assumes both ends share clk_sys and that every signal is sampled at its rising edge.
`timescale 1ns/10ps
module bprb_assertions
  import bprb_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_ack_after_take; $rose(req) |=> ack; endproperty
  a_ack_after_take: assert property (p_ack_after_take) else $error("ack not one cycle after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ack |-> req && $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_req_hold; req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  // Device only takes a fresh request after a low cycle, so the host must leave a gap
  property p_req_gap; ack |=> !req ##1 !req; endproperty
  a_req_gap: assert property (p_req_gap) else $error("request gap too short");
  property p_reserved_zero;
    req && we |-> !((addr == ADDR_UNUSED_SLOT && wdata != 8'h00) ||
                    (addr == ADDR_ANALOG_SELECT && wdata[5:4] != 2'h0) ||
                    (addr == ADDR_SWITCH_DRIVE && wdata[5:2] != 4'h0) ||
                    (addr == ADDR_WRITE_GUARD && wdata[2:0] != 3'h0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit written as one");
  property p_no_high_write; req && we |-> addr <= ADDR_LAST_VALID; endproperty
  a_no_high_write: assert property (p_no_high_write) else $error("write to reserved address");
  property p_rdata_on_read; $changed(rdata) |-> ack && !we; endproperty
  a_rdata_on_read: assert property (p_rdata_on_read) else $error("read data moved outside a read");

  c_write: cover property (ack && we);
  c_fault_read: cover property (ack && !we && addr == ADDR_FAULT_STATUS && rdata != 8'h00);
  c_guarded_write: cover property (ack && we && addr == ADDR_DISCHARGE_SET);
endmodule // bprb_assertions

// ### verification/battery_protect_register_bank_tb_top.sv
// Bench for both ends of the register bank: software talks APB to the host end, which reaches the device.
// Assumes one 50 MHz clock; fault inputs and wake pin are driven directly and settle through the synchronisers.
`timescale 1ns/10ps
module battery_protect_register_bank_tb_top
  import bprb_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [5:0]  cond    = 6'h00;
  logic        wake_pin = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err, wake_pin_status, sleep_force, load_monitor_connect;
  logic        charge_switch_on, discharge_switch_on, force_por_pulse;
  logic [5:0]  fault_flags;
  logic [3:0]  analog_select, user_flags;
  logic [7:0]  discharge_settings, charge_settings, feature_settings, e;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_por = 0;

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (force_por_pulse === 1'b1) n_por++;
  end

  bprb_link_if link_a ();
  bprb_host i_bprb_host (.clk_sys(clk_sys), .srst(srst), .link(link_a), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  bprb_device i_bprb_device (.clk_sys(clk_sys), .srst(srst), .link(link_a),
    .external_overheat_cond(cond[5]), .internal_overheat_cond(cond[4]), .load_failure_cond(cond[3]),
    .discharge_short_cond(cond[2]), .discharge_overcurrent_cond(cond[1]), .charge_overcurrent_cond(cond[0]),
    .wake_pin(wake_pin), .wake_pin_status(wake_pin_status), .fault_flags(fault_flags),
    .analog_select(analog_select), .user_flags(user_flags), .sleep_force(sleep_force),
    .load_monitor_connect(load_monitor_connect), .charge_switch_on(charge_switch_on),
    .discharge_switch_on(discharge_switch_on), .discharge_settings(discharge_settings),
    .charge_settings(charge_settings), .feature_settings(feature_settings), .force_por_pulse(force_por_pulse));
  bprb_assertions i_bprb_assertions (.clk_sys(clk_sys), .srst(srst), .req(link_a.req), .we(link_a.we),
    .addr(link_a.addr), .wdata(link_a.wdata), .ack(link_a.ack), .rdata(link_a.rdata));

  task automatic close_out;
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Holds the request until pready is seen; the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link transfer, then poll busy; rd[15:8] is the last byte read
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, APB_COMMAND, {15'h0000, w, d, a});
    do begin
      apb(1'b0, APB_STATUS, 32'h0000_0000);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 50);
    if (rd[STAT_BUSY_BIT] !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: busy stuck", $time);
    end
  endtask

  task automatic rdreg(input logic [7:0] a, input logic [7:0] exp);
    cmd(1'b0, a, 8'h00);
    check(rd[15:8], exp);
  endtask

  initial begin
    wait_cyc(10);
    srst <= 1'b0;
    apb(1'b0, APB_IRQ_STATUS, 32'h0000_0000);
    check(rd[7:0], 8'h00);
    check({7'h00, sleep_force}, 8'h00);
    rdreg(ADDR_CONFIG_STATUS, 8'h20);
    cmd(1'b1, ADDR_CONFIG_STATUS, 8'hFF);
    rdreg(ADDR_CONFIG_STATUS, 8'h20);
    cmd(1'b1, ADDR_FAULT_STATUS, 8'h3F);
    rdreg(ADDR_FAULT_STATUS, 8'h00);
    cmd(1'b1, ADDR_ANALOG_SELECT, 8'hF5);
    rdreg(ADDR_ANALOG_SELECT, 8'hC5);
    check({analog_select, user_flags}, 8'h53);
    cmd(1'b1, ADDR_WRITE_GUARD, 8'h18);
    check({analog_select, user_flags}, 8'h5F);
    apb(1'b1, APB_IRQ_CLEAR, 32'h0000_0003);
    cmd(1'b1, ADDR_DISCHARGE_SET, 8'h90);
    apb(1'b0, APB_IRQ_STATUS, 32'h0000_0000);
    check({7'h00, rd[IRQ_REFUSED_BIT]}, 8'h01);
    check(discharge_settings, 8'h00);
    apb(1'b1, APB_IRQ_CLEAR, 32'h0000_0003);
    cmd(1'b1, 8'h09, 8'h00);
    apb(1'b0, APB_IRQ_STATUS, 32'h0000_0000);
    check({7'h00, rd[IRQ_REFUSED_BIT]}, 8'h01);
    cmd(1'b1, ADDR_WRITE_GUARD, 8'hF8);
    cmd(1'b1, ADDR_DISCHARGE_SET, 8'h90);
    check(discharge_settings, 8'h90);
    rdreg(ADDR_DISCHARGE_SET, 8'h90);
    cmd(1'b1, ADDR_CHARGE_SET, 8'h5A);
    check(charge_settings, 8'h5A);
    cmd(1'b1, ADDR_SWITCH_DRIVE, 8'h03);
    check({6'h00, charge_switch_on, discharge_switch_on}, 8'h03);
    // Automatic short response is off here, so the switches must survive the short
    cond <= 6'h04;
    wait_cyc(8);
    rdreg(ADDR_SWITCH_DRIVE, 8'h03);
    cond <= 6'h00;
    wait_cyc(8);
    rdreg(ADDR_FAULT_STATUS, 8'h04);
    rdreg(ADDR_FAULT_STATUS, 8'h00);
    cmd(1'b1, ADDR_DISCHARGE_SET, 8'h00);
    cond <= 6'h04;
    wait_cyc(8);
    rdreg(ADDR_SWITCH_DRIVE, 8'h00);
    check({6'h00, charge_switch_on, discharge_switch_on}, 8'h00);
    cond <= 6'h00;
    wait_cyc(8);
    rdreg(ADDR_FAULT_STATUS, 8'h04);
    cmd(1'b1, ADDR_SWITCH_DRIVE, 8'h40);
    check({7'h00, load_monitor_connect}, 8'h01);
    for (int b = 0; b < 6; b++) begin
      e = 8'h01 << b;
      cond <= 6'h01 << b;
      wait_cyc(8);
      cond <= 6'h00;
      wait_cyc(8);
      rdreg(ADDR_FAULT_STATUS, e);
      rdreg(ADDR_FAULT_STATUS, 8'h00);
    end
    cond <= 6'h01;
    wait_cyc(8);
    rdreg(ADDR_FAULT_STATUS, 8'h01);
    rdreg(ADDR_FAULT_STATUS, 8'h01);
    cond <= 6'h00;
    wait_cyc(8);
    rdreg(ADDR_FAULT_STATUS, 8'h01);
    rdreg(ADDR_FAULT_STATUS, 8'h00);
    cmd(1'b1, ADDR_SWITCH_DRIVE, 8'h80);
    check({7'h00, sleep_force}, 8'h01);
    wake_pin <= 1'b0;
    wait_cyc(8);
    check({7'h00, sleep_force}, 8'h00);
    rdreg(ADDR_CONFIG_STATUS, 8'h30);
    wake_pin <= 1'b1;
    wait_cyc(8);
    rdreg(ADDR_CONFIG_STATUS, 8'h20);
    cmd(1'b1, ADDR_SWITCH_DRIVE, 8'h80);
    cmd(1'b1, ADDR_SWITCH_DRIVE, 8'h00);
    check({7'h00, sleep_force}, 8'h00);
    cmd(1'b1, ADDR_FEATURE_SET, 8'h05);
    check(feature_settings, 8'h01);
    check(n_por[7:0], 8'h01);
    rdreg(ADDR_CONFIG_STATUS, 8'h30);
    apb(1'b1, APB_IRQ_CLEAR, 32'h0000_0003);
    apb(1'b1, APB_IRQ_ENABLE, 32'h0000_0001);
    cmd(1'b0, ADDR_CONFIG_STATUS, 8'h00);
    wait_cyc(3);
    check({7'h00, irq}, 8'h01);
    apb(1'b1, APB_IRQ_ENABLE, 32'h0000_0000);
    wait_cyc(3);
    check({7'h00, irq}, 8'h00);
    apb(1'b0, APB_IRQ_STATUS, 32'h0000_0000);
    check({7'h00, rd[IRQ_DONE_BIT]}, 8'h01);
    apb(1'b1, APB_IRQ_CLEAR, 32'h0000_0001);
    apb(1'b0, APB_IRQ_STATUS, 32'h0000_0000);
    check(rd[7:0], 8'h00);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check({7'h00, err}, 8'h01);
    close_out();
  end

  // Tests need well under 20000 cycles
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule // battery_protect_register_bank_tb_top
